// >>> rtl/pexw_bridge.sv
/*
  Parallel expansion bus bridge: demultiplexes the host bus, decodes the window
  into an active-low select, steers the data bus and forwards SPI and reset.
  Assumes host pins are synchronous to mclk and the host sets sector waits itself.
*/
`timescale 1ns/1ps
module pexw_bridge
  import pexw_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Host external memory interface
  input  wire pexw_host_t  host,
  output logic      [7:0]  host_ad_out,
  output logic             host_ad_oe,
  // Host SPI
  input  wire pexw_spi_t   host_spi,
  output logic             host_miso,
  // Expansion bus
  output logic      [15:0] exp_addr,
  input  wire logic [7:0]  exp_data_in,
  output logic      [7:0]  exp_data_out,
  output logic             exp_data_oe,
  output logic             exp_rd_n,
  output logic             exp_wr_n,
  output logic             exp_sel_n,
  output logic             buffered_reset_out,
  // Expansion SPI
  output logic             exp_mosi,
  output logic             exp_sck,
  input  wire logic        exp_miso
);

  typedef enum logic [1:0] {
    PEXW_IDLE  = 2'b00,
    PEXW_READ  = 2'b01,
    PEXW_WRITE = 2'b10
  } pexw_state_t;

  logic [15:0] lat_addr;
  logic        ale_fall;
  logic        strobe_act;
  logic        win_hit;
  pexw_state_t state_ff;
  pexw_state_t nxt_state;
  logic [7:0]  host_ad_out_ff;
  logic        host_ad_oe_ff;
  logic [7:0]  exp_data_out_ff;
  logic        exp_data_oe_ff;
  logic        exp_rd_n_ff;
  logic        exp_wr_n_ff;
  logic        exp_sel_n_ff;
  logic        rst_out_ff;
  logic        mosi_ff;
  logic        sck_ff;

  assign strobe_act = ~host.rd_n | ~host.wr_n;
  assign win_hit    = pexw_in_window(lat_addr);

  pexw_addr_latch u_pexw_addr_latch (
    .mclk       (mclk),
    .rstn       (rstn),
    .ad_in      (host.ad_in),
    .addr_hi    (host.addr_hi),
    .ale        (host.ale),
    .strobe_act (strobe_act),
    .addr       (lat_addr),
    .ale_fall   (ale_fall)
  );

  // Access phase, used only to steer the data bus direction
  always_comb begin
    nxt_state = PEXW_IDLE;
    case ({~host.wr_n, ~host.rd_n})
      2'b01:   nxt_state = win_hit ? PEXW_READ : PEXW_IDLE;
      2'b10:   nxt_state = win_hit ? PEXW_WRITE : PEXW_IDLE;
      default: nxt_state = PEXW_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= PEXW_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Select follows the strobe a single cycle later, so no wait is ever needed
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      exp_sel_n_ff <= PEXW_HIGH_RST;
      exp_rd_n_ff  <= PEXW_HIGH_RST;
      exp_wr_n_ff  <= PEXW_HIGH_RST;
    end else begin
      exp_sel_n_ff <= ~(win_hit & strobe_act);
      exp_rd_n_ff  <= host.rd_n;
      exp_wr_n_ff  <= host.wr_n;
    end
  end

  // Write data toward the peripheral; driven only for writes in the window
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      exp_data_out_ff <= PEXW_ADDR_RST;
      exp_data_oe_ff  <= PEXW_LOW_RST;
    end else begin
      exp_data_out_ff <= host.ad_in;
      exp_data_oe_ff  <= (nxt_state == PEXW_WRITE);
    end
  end

  // Read data toward the host; one byte per read strobe in the window
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      host_ad_out_ff <= PEXW_ADDR_RST;
      host_ad_oe_ff  <= PEXW_LOW_RST;
    end else begin
      host_ad_out_ff <= exp_data_in;
      host_ad_oe_ff  <= (nxt_state == PEXW_READ);
    end
  end

  // Reset and SPI buffers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_out_ff <= PEXW_LOW_RST;
      mosi_ff    <= PEXW_LOW_RST;
      sck_ff     <= PEXW_LOW_RST;
    end else begin
      rst_out_ff <= PEXW_HIGH_RST;
      mosi_ff    <= host_spi.mosi;
      sck_ff     <= host_spi.sck;
    end
  end

  // MISO is a bare wire: the host samples it directly
  assign host_miso          = exp_miso;
  assign host_ad_out        = host_ad_out_ff;
  assign host_ad_oe         = host_ad_oe_ff;
  assign exp_addr           = lat_addr;
  assign exp_data_out       = exp_data_out_ff;
  assign exp_data_oe        = exp_data_oe_ff;
  assign exp_rd_n           = exp_rd_n_ff;
  assign exp_wr_n           = exp_wr_n_ff;
  assign exp_sel_n          = exp_sel_n_ff;
  assign buffered_reset_out = rst_out_ff;
  assign exp_mosi           = mosi_ff;
  assign exp_sck            = sck_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence seq_ale_fall;
    $fell(host.ale) && !strobe_act;
  endsequence

  sequence seq_win_read;
    !host.rd_n && host.wr_n && win_hit;
  endsequence

  AST_SEL_ONLY_IN_WINDOW: assert property (
    !exp_sel_n |-> (exp_addr >= PEXW_WIN_LO) && (exp_addr <= PEXW_WIN_HI))
    else $error("select low outside the window");

  AST_SEL_FOLLOWS: assert property (
    (strobe_act && win_hit) |=> !exp_sel_n)
    else $error("select missed an access in the window");

  AST_ADDR_DEMUX: assert property (
    seq_ale_fall |=> exp_addr == {$past(host.addr_hi), $past(host.ad_in)})
    else $error("low address byte not latched at ALE fall");

  AST_NO_WAIT: assert property (
    $fell(host.rd_n) |=> !exp_rd_n ##1 ($past(host.rd_n) == exp_rd_n))
    else $error("read strobe delayed beyond one cycle");

  AST_WIN_SIZE: assert property (
    win_hit == ((lat_addr - PEXW_WIN_LO) < 16'(PEXW_WIN_BYTES)))
    else $error("window not exactly 0x5d00 bytes from its base");

  AST_MISO_PASS: assert property (
    host_miso == exp_miso)
    else $error("MISO not passed through");

  AST_SPI_FWD: assert property (
    ##1 (exp_mosi == $past(host_spi.mosi)) && (exp_sck == $past(host_spi.sck)))
    else $error("MOSI or SCK not forwarded");

  AST_DATA_DIR: assert property (
    !(exp_data_oe && host_ad_oe) and (exp_data_oe |-> !exp_wr_n && !exp_sel_n))
    else $error("data bus driven both ways or outside a write");

  AST_RESET_OUT: assert property (
    $rose(rstn) |-> ##1 buffered_reset_out [*2])
    else $error("buffered reset not released");

  AST_READ_BYTE: assert property (
    seq_win_read |=> host_ad_oe && (host_ad_out == $past(exp_data_in)))
    else $error("read byte not passed to host");

endmodule : pexw_bridge

// >>> rtl/pexw_pkg.sv
/*
  Shared constants and carrier types for the parallel expansion bus bridge.
  Assumes one 100 MHz clock and host pins that are already synchronous to it.
*/
package pexw_pkg;

  // Expansion window, inclusive bounds
  localparam logic [15:0] PEXW_WIN_LO    = 16'ha200;
  localparam logic [15:0] PEXW_WIN_HI    = 16'hfeff;
  localparam int          PEXW_WIN_BYTES = 23808;

  // Reset values
  localparam logic [7:0]  PEXW_ADDR_RST  = 8'h00;
  localparam logic        PEXW_HIGH_RST  = 1'b1;
  localparam logic        PEXW_LOW_RST   = 1'b0;

  // Host strobe timing: no wait cycles are ever inserted by the bridge
  localparam int          PEXW_CLK_NS    = 10;
  localparam int          PEXW_LAT_CYC   = 1;

  // Host external memory interface pins as seen by the bridge
  typedef struct packed {
    logic [7:0] ad_in;
    logic [7:0] addr_hi;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
  } pexw_host_t;

  // SPI lines from the host
  typedef struct packed {
    logic mosi;
    logic sck;
  } pexw_spi_t;

  function automatic logic pexw_in_window(input logic [15:0] addr);
    pexw_in_window = (addr >= PEXW_WIN_LO) && (addr <= PEXW_WIN_HI);
  endfunction : pexw_in_window

endpackage : pexw_pkg

// >>> rtl/pexw_addr_latch.sv
/*
  Address demultiplexer: catches the low address byte from the shared lines.
  Assumes ALE and strobes are sampled on mclk and the host holds A[15:8] at ALE fall.
*/
`timescale 1ns/1ps
module pexw_addr_latch
  import pexw_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Host side
  input  wire logic [7:0]  ad_in,
  input  wire logic [7:0]  addr_hi,
  input  wire logic        ale,
  input  wire logic        strobe_act,
  // Latched address and ALE falling-edge detect
  output logic      [15:0] addr,
  output logic             ale_fall
);

  logic        ale_q_ff;
  logic [15:0] addr_ff;

  assign addr     = addr_ff;
  assign ale_fall = ale_q_ff & ~ale;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ale_q_ff <= PEXW_LOW_RST;
    end else begin
      ale_q_ff <= ale;
    end
  end

  // A new address is never taken mid-strobe, so the peripheral sees it stable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      addr_ff <= {PEXW_ADDR_RST, PEXW_ADDR_RST};
    end else if (ale_fall && !strobe_act) begin
      addr_ff <= {addr_hi, ad_in};
    end
  end

  AST_ADDR_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
    strobe_act |=> $stable(addr_ff))
    else $error("address changed during a strobe");

endmodule : pexw_addr_latch

// >>> sim/pexw_periph_model.sv
/*
  Peripheral model on the expansion bus: a 256-byte store indexed by the low address byte.
  Assumes the bridge strobes and select are registered on mclk.
*/
`timescale 1ns/1ps
module pexw_periph_model
  import pexw_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Expansion bus
  input  wire logic [15:0] exp_addr,
  input  wire logic [7:0]  exp_data_out,
  input  wire logic        exp_data_oe,
  input  wire logic        exp_rd_n,
  input  wire logic        exp_wr_n,
  input  wire logic        exp_sel_n,
  output logic      [7:0]  exp_data_in
);
  logic [7:0] mem_ff [256] = '{default: 8'h00};
  logic [7:0] last_ff      = 8'h00;
  logic [7:0] blk_sel_n;
  logic [7:0] blk_wr_sel_n;
  logic [7:0] blk_rd_sel_n;

  // Sub-decoder: eight 64-byte blocks, repeating every 512 bytes of the window
  for (genvar i = 0; i < 8; i++) begin : g_blk
    assign blk_sel_n[i]    = exp_sel_n | (exp_addr[8:6] != 3'(i));
    assign blk_wr_sel_n[i] = blk_sel_n[i] | exp_wr_n;
    assign blk_rd_sel_n[i] = blk_sel_n[i] | exp_rd_n;
  end

  // Strobes count only while selected; stored bytes read back for read-modify-write
  always_ff @(posedge mclk) begin
    if (!(&blk_wr_sel_n) && exp_data_oe) mem_ff[exp_addr[7:0]] <= exp_data_out;
    last_ff <= exp_data_in;
  end

  // Released bus toggles every cycle so a stale byte can never look right
  assign exp_data_in = !(&blk_rd_sel_n) ? mem_ff[exp_addr[7:0]] : ~last_ff;
endmodule : pexw_periph_model

// >>> sim/pexw_bridge_tb_top.sv
/*
  Self-checking bench for the expansion bus bridge: host accesses, SPI and reset.
  Assumes one 100 MHz clock; expectations queue up and a watcher compares them.
*/
`timescale 1ns/1ps
module pexw_bridge_tb_top
  import pexw_pkg::*;
;
  logic mclk = 0, rstn = 0, exp_miso = 0, exp_mosi, exp_sck, host_miso, host_ad_oe, exp_data_oe;
  logic exp_rd_n, exp_wr_n, exp_sel_n, buffered_reset_out, act;
  logic [25:0] seen_rd, seen_wr;
  logic [15:0] bound_addrs [6] = '{16'ha1ff, 16'ha200, 16'hfeff, 16'hff00, 16'h2200, 16'hffff};
  logic [2:0] limit_codes [7] = '{3'b000, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110, 3'b111};
  // Host wait-state setup; the host, not the bridge, stretches its strobes
  logic [2:0] sector_limit_select = 3'b000;
  logic [1:0] sector_wait_select_hi = 2'b00, sector_wait_select_lo = 2'b00;
  logic [7:0] host_memory_control_a = 8'h00;
  logic external_memory_enable;
  int run_len = 0;
  assign external_memory_enable = host_memory_control_a[7];
  logic [7:0] host_ad_out, exp_data_in, exp_data_out, shadow [256] = '{default: 8'h00};
  logic [15:0] exp_addr;
  logic [25:0] notes [$];
  pexw_host_t host = '{ad_in: 8'h00, addr_hi: 8'h00, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
  pexw_spi_t host_spi = '0;
  logic [31:0] seed = 32'h4;
  int bad_count = 0, tests_run = 0, cyc = 0;

  pexw_bridge u_pexw_bridge (.mclk(mclk), .rstn(rstn), .host(host), .host_ad_out(host_ad_out),
    .host_ad_oe(host_ad_oe), .host_spi(host_spi), .host_miso(host_miso), .exp_addr(exp_addr),
    .exp_data_in(exp_data_in), .exp_data_out(exp_data_out), .exp_data_oe(exp_data_oe),
    .exp_rd_n(exp_rd_n), .exp_wr_n(exp_wr_n), .exp_sel_n(exp_sel_n),
    .buffered_reset_out(buffered_reset_out), .exp_mosi(exp_mosi), .exp_sck(exp_sck), .exp_miso(exp_miso));
  pexw_periph_model u_pexw_periph_model (.mclk(mclk), .exp_addr(exp_addr), .exp_data_out(exp_data_out),
    .exp_data_oe(exp_data_oe), .exp_rd_n(exp_rd_n), .exp_wr_n(exp_wr_n), .exp_sel_n(exp_sel_n),
    .exp_data_in(exp_data_in));

  initial begin
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [25:0] seen, input logic [25:0] want);
    tests_run++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Host sector split: 0 lower, 1 upper
  function automatic int sector_of(input logic [15:0] a);
    case (sector_limit_select)
      3'b010:  return int'(a >= 16'h4000);
      3'b011:  return int'(a >= 16'h6000);
      3'b100:  return int'(a >= 16'h8000);
      3'b101:  return int'(a >= 16'ha000);
      3'b110:  return int'(a >= 16'hc000);
      3'b111:  return int'(a >= 16'he000);
      default: return 1;
    endcase
  endfunction : sector_of

  // Host cycle: ALE pulse, then a strobe of two cycles plus the sector's wait cycles
  task automatic acc(input logic [15:0] a, input logic wr, input logic [7:0] d);
    logic win;
    int n;
    logic [1:0] ws;
    if (!external_memory_enable) return;
    win = (a >= 16'ha200) && (a <= 16'hfeff);
    n = sector_of(a);
    ws = {sector_wait_select_hi[n], sector_wait_select_lo[n]};
    @(posedge mclk);
    host.ale <= 1'b1;
    host.ad_in <= a[7:0];
    host.addr_hi <= a[15:8];
    @(posedge mclk);
    host.ale <= 1'b0;
    @(posedge mclk);
    host.wr_n <= !wr;
    host.rd_n <= wr;
    host.ad_in <= d;
    notes.push_back({a, !win, win, win ? (wr ? d : shadow[a[7:0]]) : 8'h00});
    if (wr && win) shadow[a[7:0]] = d;
    repeat ((ws == 2'b00) ? 2 : (ws == 2'b01) ? 3 : 4) @(posedge mclk);
    host.wr_n <= 1'b1;
    host.rd_n <= 1'b1;
    if (ws == 2'b11) @(posedge mclk);
  endtask : acc

  // Compare on the second strobe cycle, where data from the far side has settled
  always @(negedge mclk) begin
    act = !exp_rd_n || !exp_wr_n;
    run_len = act ? run_len + 1 : 0;
    seen_rd = {exp_addr, exp_sel_n, host_ad_oe, host_ad_oe ? host_ad_out : 8'h00};
    seen_wr = {exp_addr, exp_sel_n, exp_data_oe, exp_data_oe ? exp_data_out : 8'h00};
    if (run_len == 2) begin
      if (notes.size() == 0) check(26'h0, 26'h3ffffff);
      else if (!exp_rd_n) check(seen_rd, notes.pop_front());
      else check(seen_wr, notes.pop_front());
    end
  end

  // Roughly 720 to 1,100 cycles of traffic; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    logic [15:0] a;
    logic [1:0] v;
    repeat (3) @(posedge mclk);
    @(negedge mclk) check(26'(buffered_reset_out), 26'h0);
    @(posedge mclk) rstn <= 1'b1;
    repeat (2) @(negedge mclk);
    check(26'(buffered_reset_out), 26'h1);
    $display("reset test done");
    host_memory_control_a = 8'h80;
    foreach (bound_addrs[i]) begin
      a = bound_addrs[i];
      acc(a, 1'b1, 8'(xs() >> 3));
      acc(a, 1'b0, 8'h00);
    end
    $display("window boundary test done");
    foreach (limit_codes[k]) begin
      sector_limit_select = limit_codes[k];
      {sector_wait_select_hi, sector_wait_select_lo} = 4'(xs() >> 13);
      repeat (6) begin
        a = 16'(xs() >> 7);
        acc(a, 1'b1, 8'(xs() >> 5));
        acc(a, 1'b0, 8'h00);
        acc(a, 1'(xs() >> 31), 8'(xs() >> 9));
      end
    end
    $display("random access test done");
    repeat (8) begin
      v = 2'(xs() >> 11);
      @(posedge mclk);
      host_spi <= v;
      exp_miso <= v[0];
      @(posedge mclk);
      @(negedge mclk) check(26'({exp_mosi, exp_sck, host_miso}), 26'({v, v[0]}));
    end
    $display("spi test done");
    repeat (4) @(posedge mclk);
    check(26'(notes.size()), 26'h0);
    end_of_test();
  end
endmodule : pexw_bridge_tb_top
